//--- fbs_pkg.sv
// Shared constants and types for the five-stage preset shift register
//==============================================================
// How it works
// RL1 - Five stages move only on shift clock rise
// RL2 - First takes serial input, others previous stage
// RL3 - Low clear with preset idle empties stages
// RL4 - Preset enable sets stages whose preset is high
// RL5 - Driver clears, presents data, then pulses enable
// RL6 - Driver keeps clear high, presets low when clocking
// RL7 - No edge, no clear, no preset: hold
// RL8 - All stage outputs, serial, presets exposed
// RL9 - Preset leaves stages with low preset untouched while clear is high
//==============================================================
package fbs_pkg;

  //==============================================================
  // Sizes
  localparam int STAGES     = 5;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 32;
  localparam int SEQ_W      = 4;

  //==============================================================
  // Reset values
  localparam logic [STAGES-1:0] STAGE_RESET = 5'h00;
  localparam logic [SEQ_W-1:0]  SEQ_RESET   = 4'h0;
  localparam logic [SEQ_W-1:0]  SEQ_STEP    = 4'h1;

  //==============================================================
  // Stage indices
  localparam int FIRST_STAGE = 0;
  localparam int LAST_STAGE  = STAGES - 1;

  //==============================================================
  // Parallel load tracking
  typedef enum logic [1:0] {
    LD_IDLE    = 2'b00,
    LD_CLEARED = 2'b01,
    LD_PRESET  = 2'b10
  } fbs_load_t;

  //==============================================================
  // Word pushed into the snapshot queue after every shift
  typedef struct packed {
    logic [SEQ_W-1:0]  seq;
    logic [STAGES-1:0] stages;
  } fbs_snap_t;

endpackage : fbs_pkg

//--- fbs_stage.sv
// One storage stage with clear, preset and shift
`timescale 1ns/1ps
`default_nettype none
module fbs_stage #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic ce,
  // Controls
  input  wire logic clear_n,
  input  wire logic preset_enable,
  input  wire logic preset_bit,
  input  wire logic shift_en,
  input  wire logic shift_in,
  // State
  output logic      q
);

  logic q_reg;
  logic q_next;
  logic set_now;
  logic clr_now;

  assign set_now = preset_enable & preset_bit;
  assign clr_now = ~clear_n;
  // Preset wins where its bit is high, clear takes the rest
  assign q_next  = set_now  ? 1'b1 :
                   clr_now  ? 1'b0 :
                   shift_en ? shift_in : q_reg;
  assign q       = q_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_reg <= RESET_VAL;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

endmodule : fbs_stage
`default_nettype wire

//--- fbs_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      end
      count_reg <= count_next;
    end
  end

  // Storage carries no reset
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule : fbs_fifo
`default_nettype wire

//--- fbs_shift_reg.sv
// Five-stage shift register with clear, per-stage preset and snapshot queue
`timescale 1ns/1ps
`default_nettype none
module fbs_shift_reg
  import fbs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              ce,
  // Shift pins
  input  wire logic              shift_clock,
  input  wire logic              serial_in,
  // Clear and preset pins
  input  wire logic              clear_n,
  input  wire logic              preset_enable,
  input  wire logic [STAGES-1:0] preset_in,
  // Stage outputs
  output logic                   first_stage_output,
  output logic                   second_stage_output,
  output logic                   third_stage_output,
  output logic                   fourth_stage_output,
  output logic                   last_stage_output,
  output logic [STAGES-1:0]      stage_word,
  // Shift acceptance
  output logic                   shift_ready,
  // Snapshot stream
  output logic                   snap_valid,
  input  wire logic              snap_ready,
  output fbs_snap_t              snap_data,
  // Status
  output fbs_load_t              load_phase,
  output logic                   load_order_err,
  output logic                   shift_conflict,
  input  wire logic              err_clear
);

  //==============================================================
  // Shift clock edge detection
  logic shift_clock_prev_reg;
  logic shift_rise;

  assign shift_rise = shift_clock & ~shift_clock_prev_reg; // [RL1]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shift_clock_prev_reg <= 1'b0;
    end else if (ce) begin
      shift_clock_prev_reg <= shift_clock;
    end
  end

  //==============================================================
  // Shift decision
  logic pending_reg;
  logic pending_next;
  logic pend_bit_reg;
  logic shift_bit;
  logic edge_now;
  logic quiet;
  logic queue_ready;
  logic shift_go;
  logic shift_drop;

  // Edge only counts while clear and preset are idle
  assign quiet        = clear_n & ~preset_enable; // [RL6]
  assign edge_now     = shift_rise | pending_reg;
  assign shift_go     = edge_now & quiet & queue_ready; // [RL1]
  assign shift_drop   = edge_now & ~quiet;
  // A full queue holds the edge until room appears
  assign pending_next = edge_now & quiet & ~queue_ready;
  assign shift_ready  = queue_ready & ~pending_reg;
  // A held edge keeps the serial bit seen at its rise
  assign shift_bit    = pending_reg ? pend_bit_reg : serial_in; // [RL2]

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pending_reg  <= 1'b0;
      pend_bit_reg <= 1'b0;
    end else if (ce) begin
      pending_reg  <= pending_next;
      if (!pending_reg) begin
        pend_bit_reg <= serial_in;
      end
    end
  end

  //==============================================================
  // Stage chain
  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_in;

  assign stage_in[FIRST_STAGE] = shift_bit; // [RL2]
  assign stage_in[LAST_STAGE:FIRST_STAGE+1] = stage_q[LAST_STAGE-1:FIRST_STAGE]; // [RL2]

  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_stage
      fbs_stage #(
        .RESET_VAL (STAGE_RESET[gi])
      ) u_stage (
        .mclk          (mclk),
        .resetn        (resetn),
        .ce            (ce),
        .clear_n       (clear_n),       // [RL3]
        .preset_enable (preset_enable), // [RL4] [RL9]
        .preset_bit    (preset_in[gi]),
        .shift_en      (shift_go),      // [RL7]
        .shift_in      (stage_in[gi]),
        .q             (stage_q[gi])
      );
    end
  endgenerate

  // Every stage visible in parallel
  assign first_stage_output  = stage_q[0]; // [RL8]
  assign second_stage_output = stage_q[1]; // [RL8]
  assign third_stage_output  = stage_q[2]; // [RL8]
  assign fourth_stage_output = stage_q[3]; // [RL8]
  assign last_stage_output   = stage_q[LAST_STAGE]; // [RL8]
  assign stage_word          = stage_q;

  //==============================================================
  // Snapshot queue, one entry per shift
  logic [SEQ_W-1:0] seq_reg;
  fbs_snap_t        push_word;
  logic [FIFO_WIDTH-1:0] pop_bits;

  assign push_word.seq    = seq_reg;
  assign push_word.stages = stage_in;
  assign snap_data        = fbs_snap_t'(pop_bits);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seq_reg <= SEQ_RESET;
    end else if (ce && shift_go) begin
      seq_reg <= seq_reg + SEQ_STEP;
    end
  end

  fbs_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (shift_go),
    .in_ready  (queue_ready),
    .in_data   (push_word),
    .out_valid (snap_valid),
    .out_ready (snap_ready),
    .out_data  (pop_bits)
  );

  //==============================================================
  // Parallel load order tracking
  fbs_load_t phase_reg;
  fbs_load_t phase_next;
  logic      clearing;
  logic      order_bad;

  assign clearing  = ~clear_n & ~preset_enable;
  // Preset start without a prior clear breaks the load order
  assign order_bad = preset_enable & (phase_reg == LD_IDLE); // [RL5]

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      LD_IDLE: begin
        if (preset_enable) begin
          phase_next = LD_PRESET;
        end else if (clearing) begin
          phase_next = LD_CLEARED;
        end
      end
      LD_CLEARED: begin
        if (preset_enable) begin
          phase_next = LD_PRESET;
        end else if (shift_go) begin
          phase_next = LD_IDLE;
        end
      end
      LD_PRESET: begin
        if (!preset_enable) begin
          phase_next = clearing ? LD_CLEARED : LD_IDLE;
        end
      end
      default: begin
        phase_next = LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= LD_IDLE;
    end else if (ce) begin
      phase_reg <= phase_next;
    end
  end

  assign load_phase = phase_reg;

  //==============================================================
  // Sticky error flags, a new event wins over the clear
  logic order_err_reg;
  logic conflict_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      order_err_reg <= 1'b0;
      conflict_reg  <= 1'b0;
    end else if (ce) begin
      order_err_reg <= order_bad  | (order_err_reg & ~err_clear); // [RL5]
      conflict_reg  <= shift_drop | (conflict_reg & ~err_clear);  // [RL6]
    end
  end

  assign load_order_err = order_err_reg;
  assign shift_conflict = conflict_reg;

endmodule : fbs_shift_reg
`default_nettype wire

//--- fbs_shift_reg_assertions.sv
// Port checks for the five-stage shift register
`timescale 1ns/1ps
`default_nettype none
module fbs_sr_checker
  import fbs_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              ce,
  // Pins
  input wire logic              shift_clock,
  input wire logic              serial_in,
  input wire logic              clear_n,
  input wire logic              preset_enable,
  input wire logic [STAGES-1:0] preset_in,
  // Outputs
  input wire logic [STAGES-1:0] stage_word,
  input wire logic              shift_ready,
  input wire logic              snap_valid,
  input wire logic              shift_conflict
);
  logic              sc_reg;
  logic              rise;
  logic              idle;
  logic              go;
  logic [STAGES-2:0] low;
  //======================================
  // Shift edge as the design samples it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sc_reg <= 1'b0;
    end else if (ce) begin
      sc_reg <= shift_clock;
    end
  end
  assign rise = ce & shift_clock & ~sc_reg;
  assign idle = clear_n & ~preset_enable;
  assign go   = rise & idle & shift_ready;
  assign low  = stage_word[STAGES-2:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  //======================================
  // Assertions
  AST_CLEAR: assert property (ce && !clear_n && !preset_enable |=> stage_word == 5'h00)
    else $error("stages not cleared");
  AST_PRESET: assert property (ce && preset_enable |=> (stage_word & $past(preset_in)) == $past(preset_in))
    else $error("preset stage not set");
  AST_KEEP: assert property (ce && preset_enable && clear_n |=>
    (stage_word | $past(preset_in)) == ($past(stage_word) | $past(preset_in)))
    else $error("unpreset stage changed");
  AST_SHIFT: assert property (go |=> stage_word == {$past(low), $past(serial_in)})
    else $error("shift result wrong");
  AST_HOLD: assert property (ce && idle && shift_ready && !rise |=> $stable(stage_word))
    else $error("stages moved without cause");
  AST_FREEZE: assert property (!ce |=> $stable(stage_word))
    else $error("stages moved with enable low");
  AST_CONFLICT: assert property (rise && !idle |=> shift_conflict)
    else $error("conflict not flagged");
  AST_SNAP: assert property (go |=> snap_valid)
    else $error("no snapshot after shift");
  cover property (go);
  cover property (ce && preset_enable);
  cover property (rise && !shift_ready);
endmodule : fbs_sr_checker

bind fbs_shift_reg fbs_sr_checker u_fbs_sr_checker (
  .mclk, .resetn, .ce, .shift_clock, .serial_in, .clear_n, .preset_enable, .preset_in,
  .stage_word, .shift_ready, .snap_valid, .shift_conflict
);
`default_nettype wire

//--- fbs_pin_driver.sv
// Model of the logic that drives the register pins
`timescale 1ns/1ps
`default_nettype none
module fbs_pin_driver
  import fbs_pkg::*;
(
  // Clock
  input wire logic          mclk,
  // Register pins
  output logic              shift_clock,
  output logic              serial_in,
  output logic              clear_n,
  output logic              preset_enable,
  output logic [STAGES-1:0] preset_in
);
  initial begin
    shift_clock   = 1'b0;
    serial_in     = 1'b0;
    clear_n       = 1'b1;
    preset_enable = 1'b0;
    preset_in     = 5'h00;
  end
  //======================================
  // One shift; keep_clr low breaks clocking
  task automatic shift(input logic d, input logic keep_clr);
    @(negedge mclk);
    clear_n     = keep_clr;
    @(negedge mclk);
    shift_clock = 1'b1;
    serial_in   = d;
    @(negedge mclk);
    shift_clock = 1'b0;
    serial_in   = ~d;
    clear_n     = 1'b1;
  endtask : shift
  //======================================
  // Parallel load; clr low skips clearing
  task automatic load(input logic [STAGES-1:0] p, input logic clr);
    @(negedge mclk);
    clear_n       = ~clr;
    @(negedge mclk);
    clear_n       = 1'b1;
    preset_in     = p;
    preset_enable = 1'b1;
    @(negedge mclk);
    preset_enable = 1'b0;
    preset_in     = 5'h00;
  endtask : load
endmodule : fbs_pin_driver
`default_nettype wire

//--- fbs_shift_reg_test.sv
// Self-checking bench for the five-stage shift register
`timescale 1ns/1ps
`default_nettype none
module fbs_shift_reg_test
  import fbs_pkg::*;
;
  logic              mclk;
  logic              resetn;
  logic              ce;
  logic              shift_clock;
  logic              serial_in;
  logic              clear_n;
  logic              preset_enable;
  logic [STAGES-1:0] preset_in;
  logic              snap_ready;
  logic              err_clear;
  logic [STAGES-1:0] stage_word;
  logic [STAGES-1:0] taps;
  logic              shift_ready;
  logic              snap_valid;
  fbs_snap_t         snap_data;
  logic              shift_conflict;
  logic              load_order_err;
  fbs_load_t         load_phase;
  int                n_mismatch;
  int                checked;

  fbs_pin_driver u_fbs_pin_driver (
    .mclk, .shift_clock, .serial_in, .clear_n, .preset_enable, .preset_in
  );
  fbs_shift_reg u_fbs_shift_reg (
    .mclk, .resetn, .ce, .shift_clock, .serial_in, .clear_n, .preset_enable, .preset_in,
    .first_stage_output(taps[0]), .second_stage_output(taps[1]), .third_stage_output(taps[2]),
    .fourth_stage_output(taps[3]), .last_stage_output(taps[4]), .stage_word, .shift_ready,
    .snap_valid, .snap_ready, .snap_data, .load_phase, .load_order_err, .shift_conflict, .err_clear
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  //======================================
  // Checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic close_out;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  //======================================
  // Scenarios
  task automatic t_load;
    u_fbs_pin_driver.load(5'h15, 1'b1);
    chk(8'(stage_word), 8'h15);
    chk(8'({load_phase, load_order_err}), 8'h04);
    u_fbs_pin_driver.load(5'h02, 1'b0);
    chk(8'(stage_word), 8'h17);
    chk(8'({load_phase, load_order_err}), 8'h05);
    $display("t_load done");
  endtask : t_load

  task automatic t_shift;
    logic [STAGES-1:0] want;
    want = 5'h17;
    for (int i = 0; i < 7; i++) begin
      u_fbs_pin_driver.shift(i[0] ^ i[2], 1'b1);
      want = {want[STAGES-2:0], i[0] ^ i[2]};
      chk(8'(taps), 8'(want));
    end
    ce = 1'b0;
    u_fbs_pin_driver.shift(~want[0], 1'b1);
    ce = 1'b1;
    repeat (8) @(negedge mclk);
    chk(8'(stage_word), 8'(want));
    $display("t_shift done");
  endtask : t_shift

  task automatic t_conflict;
    u_fbs_pin_driver.shift(1'b1, 1'b0);
    @(negedge mclk);
    chk(8'(stage_word), 8'h00);
    chk(8'(shift_conflict), 8'h01);
    err_clear = 1'b1;
    @(negedge mclk);
    err_clear = 1'b0;
    chk(8'({shift_conflict, load_order_err}), 8'h00);
    $display("t_conflict done");
  endtask : t_conflict

  task automatic t_fifo;
    int n;
    snap_ready = 1'b0;
    for (int i = 0; i < 33; i++) begin
      u_fbs_pin_driver.shift(1'b1, 1'b1);
    end
    chk(8'(shift_ready), 8'h00);
    chk(8'(snap_data.stages), 8'h01);
    chk(8'(snap_data.seq), 8'h07);
    snap_ready = 1'b1;
    n = 0;
    repeat (40) begin
      n += (snap_valid === 1'b1);
      @(negedge mclk);
    end
    chk(8'(n), 8'h21);
    chk(8'(shift_ready), 8'h01);
    chk(8'(stage_word), 8'h1f);
    $display("t_fifo done");
  endtask : t_fifo

  initial begin
    resetn     = 1'b0;
    ce         = 1'b1;
    snap_ready = 1'b1;
    err_clear  = 1'b0;
    n_mismatch = 0;
    checked    = 0;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    chk(8'({shift_ready, snap_valid, stage_word}), 8'h40);
    t_load();
    t_shift();
    t_conflict();
    t_fifo();
    close_out();
  end
endmodule : fbs_shift_reg_test
`default_nettype wire
